// ### read_burst_pkg.sv
package read_burst_pkg;

  // widths and burst shape
  localparam int DATA_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int BYTES     = 2;
  localparam int BUF_DEPTH = 2;

  localparam logic [4:0] BURST_LEN = 5'h10;
  localparam logic [7:0] PRE_BITS  = 8'h08;
  localparam logic [7:0] LEAD_BITS = 8'h02;
  localparam logic [3:0] MAX_ZEROS = 4'h4;

  // preamble levels: odd lines start at 0, even lines at 1
  localparam logic [DATA_W-1:0] ODD_LINES  = 16'hAAAA;
  localparam logic [DATA_W-1:0] EVEN_LINES = 16'h5555;
  localparam logic [DATA_W-1:0] ALL_HIGH   = 16'hFFFF;

  // register offsets
  localparam logic [7:0] MODE_ZERO_OFFSET  = 8'h00;
  localparam logic [7:0] MODE_ONE_OFFSET   = 8'h04;
  localparam logic [7:0] MODE_SEVEN_OFFSET = 8'h08;
  localparam logic [7:0] CONTROL_OFFSET    = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET     = 8'h10;

  // field positions
  localparam int LATENCY_POS     = 0;
  localparam int LATENCY_W       = 6;
  localparam int INV_DISABLE_POS = 8;
  localparam int PREAMBLE_EN_POS = 5;
  localparam int ODT_EN_POS      = 0;
  localparam int BANK_GROUP_POS  = 1;
  localparam int RTP_SHORT_POS   = 8;
  localparam int RTP_LONG_POS    = 12;
  localparam int RTP_W           = 4;

  // values after reset
  localparam logic [5:0] LATENCY_RESET     = 6'h0C;
  localparam logic       INV_DISABLE_RESET = 1'h1;
  localparam logic       PREAMBLE_RESET    = 1'h0;
  localparam logic       ODT_EN_RESET      = 1'h1;
  localparam logic       BANK_GROUP_RESET  = 1'h0;
  localparam logic [3:0] RTP_SHORT_RESET   = 4'h2;
  localparam logic [3:0] RTP_LONG_RESET    = 4'h4;

  typedef enum logic [2:0] {IDLE, LEAD, PRE, BURST, TAIL} state_type;

  typedef struct packed {
    logic       read;
    logic       autoPrecharge;
    logic [3:0] bank;
  } readCmd_type;

  typedef struct packed {
    logic       active;
    logic [7:0] remain;
  } slot_type;

endpackage

// ### data_clock_sync.sv
`timescale 1ns/10ps
`default_nettype none

module data_clock_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic dataClockPin,
  output var  logic bitTick,
  output var  logic riseTick
);

  logic stage1;
  logic stage2;
  logic previous;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1   <= 1'b0;
      stage2   <= 1'b0;
      previous <= 1'b0;
    end else begin
      stage1   <= dataClockPin;
      stage2   <= stage1;
      previous <= stage2;
    end
  end

  // each edge of the data clock is one bit time
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitTick  <= 1'b0;
      riseTick <= 1'b0;
    end else begin
      bitTick  <= stage2 ^ previous;
      riseTick <= stage2 & ~previous;
    end
  end

endmodule

`default_nettype wire

// ### two_entry_buffer.sv
`timescale 1ns/10ps
`default_nettype none

module two_entry_buffer (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic [read_burst_pkg::DATA_W-1:0] inData,
  input  wire logic                              inValid,
  output var  logic                              inReady,
  output var  logic [read_burst_pkg::DATA_W-1:0] outData,
  output var  logic                              outValid,
  input  wire logic                              outReady,
  output var  logic [1:0]                        level
);

  logic [read_burst_pkg::DATA_W-1:0] store [read_burst_pkg::BUF_DEPTH];
  logic                              writeIndex;
  logic                              readIndex;
  logic                              push;
  logic                              pop;
  logic [1:0]                        next_level;

  assign outValid = (level != 2'h0);
  assign outData  = store[readIndex];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_comb begin
    next_level = level;
    if (push && !pop) begin
      next_level = level + 2'h1;
    end else if (pop && !push) begin
      next_level = level - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[writeIndex] <= inData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      writeIndex <= 1'b0;
      readIndex  <= 1'b0;
      level      <= 2'h0;
      inReady    <= 1'b1;
    end else begin
      if (push) begin
        writeIndex <= ~writeIndex;
      end
      if (pop) begin
        readIndex <= ~readIndex;
      end
      level   <= next_level;
      inReady <= (next_level != 2'(read_burst_pkg::BUF_DEPTH));
    end
  end

endmodule

`default_nettype wire

// ### read_burst_preamble_timing.sv
// Overview of operation
// R1 - same bank group reads spaced by long delay
// R2 - activate bank, wait before reading it
// R3 - read-to-precharge long when same bank grouped
// R4 - auto-precharge starts at earliest legal time
// R5 - read-to-write spacing is controller's choice
// R6 - controller trains read capture offset first
// R7 - lane output skew kept within bound
// R8 - preamble before every burst when enabled
// R9 - one pattern for all lanes, bytes
// R10 - error-check pins excluded from preamble
// R11 - termination off one clock before preamble
// R12 - inversion pin preamble only with inversion on
// R13 - preamble bits never inversion encoded
// R14 - eight toggling bits, odd start low
// R15 - at most four zeros with inversion
// R16 - read latency from mode register zero
// R17 - fixed sixteen-element bursts, never cut
// R18 - after burst drive high, then terminate
// R19 - inversion pin low means inverted data
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module read_burst_preamble_timing (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              dataClockPin,
  input  wire read_burst_pkg::readCmd_type       readCmd,
  input  wire logic [read_burst_pkg::DATA_W-1:0] arrayData,
  input  wire logic                              arrayValid,
  output var  logic                              arrayReady,
  input  wire logic [7:0]                        regAddr,
  input  wire logic [31:0]                       regWdata,
  input  wire logic                              regWrite,
  input  wire logic                              regRead,
  output var  logic [31:0]                       regRdata,
  output var  logic [read_burst_pkg::DATA_W-1:0] dqOut,
  output var  logic                              dqOe,
  output var  logic [read_burst_pkg::BYTES-1:0]  invOut,
  output var  logic [read_burst_pkg::BYTES-1:0]  invOe,
  output var  logic                              odtActive,
  output var  logic                              prechargeStart,
  output var  logic [3:0]                        prechargeBank
);

  function automatic logic [3:0] zeroCount(
    input logic [read_burst_pkg::BYTE_W-1:0] lane
  );
    logic [3:0] total;
    total = 4'h0;
    for (int b = 0; b < read_burst_pkg::BYTE_W; b++) begin
      total = total + 4'(~lane[b]);
    end
    return total;
  endfunction

  logic                                       bitTick;
  logic                                       riseTick;
  logic [read_burst_pkg::LATENCY_W-1:0]       programmedReadLatency;
  logic                                       inversionDisable;
  logic                                       preambleEnable;
  logic                                       odtEnable;
  logic                                       bankGroupEnable;
  logic [read_burst_pkg::RTP_W-1:0]           readToPrechargeShort;
  logic [read_burst_pkg::RTP_W-1:0]           readToPrechargeLong;
  read_burst_pkg::slot_type                   slot [2];
  logic                                       headIndex;
  logic                                       tailIndex;
  logic                                       headStart;
  logic [7:0]                                 headRemain;
  logic                                       headActive;
  logic [7:0]                                 leadTop;
  read_burst_pkg::state_type                  state;
  read_burst_pkg::state_type                  next_state;
  logic [4:0]                                 burstLeft;
  logic [read_burst_pkg::DATA_W-1:0]          bufData;
  logic                                       bufValid;
  logic                                       bufPop;
  logic [1:0]                                 bufLevel;
  logic [read_burst_pkg::DATA_W-1:0]          encData;
  logic [read_burst_pkg::BYTES-1:0]           encFlag;
  logic [2:0]                                 preIndex;
  logic                                       readInversion;
  logic                                       rtpBusy;
  logic [read_burst_pkg::RTP_W-1:0]           rtpCount;

  data_clock_sync clockSync (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .dataClockPin (dataClockPin),
    .bitTick      (bitTick),
    .riseTick     (riseTick)
  );

  two_entry_buffer burstBuffer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (arrayData),
    .inValid  (arrayValid),
    .inReady  (arrayReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufPop),
    .level    (bufLevel)
  );

  // register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      programmedReadLatency <= read_burst_pkg::LATENCY_RESET;
      inversionDisable      <= read_burst_pkg::INV_DISABLE_RESET;
      preambleEnable        <= read_burst_pkg::PREAMBLE_RESET;
      odtEnable             <= read_burst_pkg::ODT_EN_RESET;
      bankGroupEnable       <= read_burst_pkg::BANK_GROUP_RESET;
      readToPrechargeShort  <= read_burst_pkg::RTP_SHORT_RESET;
      readToPrechargeLong   <= read_burst_pkg::RTP_LONG_RESET;
    end else if (regWrite) begin
      if (regAddr == read_burst_pkg::MODE_ZERO_OFFSET) begin
        programmedReadLatency <= regWdata[read_burst_pkg::LATENCY_POS
                                 +: read_burst_pkg::LATENCY_W]; // R16
      end else if (regAddr == read_burst_pkg::MODE_ONE_OFFSET) begin
        inversionDisable <= regWdata[read_burst_pkg::INV_DISABLE_POS];
      end else if (regAddr == read_burst_pkg::MODE_SEVEN_OFFSET) begin
        preambleEnable <= regWdata[read_burst_pkg::PREAMBLE_EN_POS]; // R8
      end else if (regAddr == read_burst_pkg::CONTROL_OFFSET) begin
        odtEnable            <= regWdata[read_burst_pkg::ODT_EN_POS];
        bankGroupEnable      <= regWdata[read_burst_pkg::BANK_GROUP_POS];
        readToPrechargeShort <= regWdata[read_burst_pkg::RTP_SHORT_POS
                                +: read_burst_pkg::RTP_W];
        readToPrechargeLong  <= regWdata[read_burst_pkg::RTP_LONG_POS
                                +: read_burst_pkg::RTP_W];
      end
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= 32'h00000000;
      if (regRead) begin
        if (regAddr == read_burst_pkg::MODE_ZERO_OFFSET) begin
          regRdata[read_burst_pkg::LATENCY_POS
                   +: read_burst_pkg::LATENCY_W] <= programmedReadLatency;
        end else if (regAddr == read_burst_pkg::MODE_ONE_OFFSET) begin
          regRdata[read_burst_pkg::INV_DISABLE_POS] <= inversionDisable;
        end else if (regAddr == read_burst_pkg::MODE_SEVEN_OFFSET) begin
          regRdata[read_burst_pkg::PREAMBLE_EN_POS] <= preambleEnable;
        end else if (regAddr == read_burst_pkg::CONTROL_OFFSET) begin
          regRdata[read_burst_pkg::ODT_EN_POS]     <= odtEnable;
          regRdata[read_burst_pkg::BANK_GROUP_POS] <= bankGroupEnable;
          regRdata[read_burst_pkg::RTP_SHORT_POS
                   +: read_burst_pkg::RTP_W] <= readToPrechargeShort;
          regRdata[read_burst_pkg::RTP_LONG_POS
                   +: read_burst_pkg::RTP_W] <= readToPrechargeLong;
        end else if (regAddr == read_burst_pkg::STATUS_OFFSET) begin
          regRdata[2:0] <= state;
          regRdata[4:3] <= {slot[1].active, slot[0].active};
          regRdata[6:5] <= bufLevel;
          regRdata[7]   <= rtpBusy;
        end
      end
    end
  end

  assign readInversion = ~inversionDisable; // R19
  assign headActive    = slot[headIndex].active;
  assign headRemain    = slot[headIndex].remain;
  assign headStart     = bitTick & headActive & (headRemain == 8'h01);
  assign leadTop       = preambleEnable
                         ? read_burst_pkg::PRE_BITS
                           + read_burst_pkg::LEAD_BITS + 8'h01
                         : read_burst_pkg::LEAD_BITS + 8'h01;
  assign preIndex      = 3'(read_burst_pkg::PRE_BITS + 8'h01 - headRemain);

  // latency slots, two reads may be in flight
  generate
    for (genvar s = 0; s < 2; s++) begin : gSlot
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          slot[s] <= '0;
        end else if (readCmd.read && tailIndex == 1'(s)) begin
          slot[s].active <= 1'b1;
          slot[s].remain <= {1'b0, programmedReadLatency, 1'b0}; // R16
        end else if (bitTick && slot[s].active) begin
          slot[s].remain <= slot[s].remain - 8'h01;
          if (headStart && headIndex == 1'(s)) begin
            slot[s].active <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      headIndex <= 1'b0;
      tailIndex <= 1'b0;
    end else begin
      if (readCmd.read) begin
        tailIndex <= ~tailIndex;
      end
      if (headStart) begin
        headIndex <= ~headIndex;
      end
    end
  end

  // output sequencing by bit time
  always_comb begin
    next_state = state;
    if (bitTick) begin
      if (headActive && headRemain == 8'h01) begin
        next_state = read_burst_pkg::BURST;
      end else if (state == read_burst_pkg::BURST && burstLeft != 5'h00) begin
        next_state = read_burst_pkg::BURST; // R17
      end else if (headActive && preambleEnable
                   && headRemain <= read_burst_pkg::PRE_BITS + 8'h01) begin
        next_state = read_burst_pkg::PRE; // R8
      end else if (headActive && headRemain <= leadTop) begin
        next_state = read_burst_pkg::LEAD; // R11
      end else if (state == read_burst_pkg::BURST) begin
        next_state = read_burst_pkg::TAIL; // R18
      end else begin
        next_state = read_burst_pkg::IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= read_burst_pkg::IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      burstLeft <= 5'h00;
    end else if (headStart) begin
      burstLeft <= read_burst_pkg::BURST_LEN - 5'h01; // R17
    end else if (bitTick && state == read_burst_pkg::BURST
                 && burstLeft != 5'h00) begin
      burstLeft <= burstLeft - 5'h01;
    end
  end

  assign bufPop = bitTick & (next_state == read_burst_pkg::BURST);

  // per-byte inversion of burst data
  generate
    for (genvar g = 0; g < read_burst_pkg::BYTES; g++) begin : gByte
      logic [read_burst_pkg::BYTE_W-1:0] lane;
      logic                              flip;
      assign lane = bufData[g*read_burst_pkg::BYTE_W
                            +: read_burst_pkg::BYTE_W];
      assign flip = readInversion
                    & (zeroCount(lane) > read_burst_pkg::MAX_ZEROS); // R15
      assign encData[g*read_burst_pkg::BYTE_W +: read_burst_pkg::BYTE_W] =
             flip ? ~lane : lane;
      assign encFlag[g] = ~flip; // R19
    end
  endgenerate

  // all lanes change on the same edge from one flop bank
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut     <= read_burst_pkg::ALL_HIGH;
      dqOe      <= 1'b0;
      invOut    <= '1;
      invOe     <= '0;
      odtActive <= read_burst_pkg::ODT_EN_RESET;
    end else if (bitTick) begin // R7
      case (next_state)
        read_burst_pkg::BURST: begin
          dqOut     <= encData;
          dqOe      <= 1'b1;
          invOut    <= encFlag;
          invOe     <= {read_burst_pkg::BYTES{readInversion}};
          odtActive <= 1'b0;
        end
        read_burst_pkg::PRE: begin // R9
          // error-check lanes are not driven from here // R10
          dqOut     <= preIndex[0] ? read_burst_pkg::ODD_LINES
                                   : read_burst_pkg::EVEN_LINES; // R14
          dqOe      <= 1'b1;
          invOut    <= {read_burst_pkg::BYTES{preIndex[0]}}; // R13
          invOe     <= {read_burst_pkg::BYTES{readInversion}}; // R12
          odtActive <= 1'b0;
        end
        read_burst_pkg::LEAD: begin
          dqOut     <= read_burst_pkg::ALL_HIGH;
          dqOe      <= 1'b1;
          invOut    <= '1;
          invOe     <= {read_burst_pkg::BYTES{readInversion}};
          odtActive <= 1'b0; // R11
        end
        read_burst_pkg::TAIL: begin
          dqOut     <= read_burst_pkg::ALL_HIGH; // R18
          dqOe      <= 1'b1;
          invOut    <= '1;
          invOe     <= {read_burst_pkg::BYTES{readInversion}};
          odtActive <= 1'b0;
        end
        default: begin
          dqOut     <= read_burst_pkg::ALL_HIGH;
          dqOe      <= 1'b0;
          invOut    <= '1;
          invOe     <= '0;
          odtActive <= odtEnable; // R18
        end
      endcase
    end
  end

  // auto-precharge timer in data clock periods
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtpBusy        <= 1'b0;
      rtpCount       <= '0;
      prechargeStart <= 1'b0;
      prechargeBank  <= 4'h0;
    end else begin
      prechargeStart <= 1'b0;
      if (readCmd.read && readCmd.autoPrecharge) begin
        rtpBusy       <= 1'b1;
        prechargeBank <= readCmd.bank;
        rtpCount      <= bankGroupEnable ? readToPrechargeLong
                                         : readToPrechargeShort; // R4
      end else if (rtpBusy && riseTick) begin
        if (rtpCount <= 4'h1) begin
          rtpBusy        <= 1'b0;
          prechargeStart <= 1'b1; // R4
        end else begin
          rtpCount <= rtpCount - 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### read_burst_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module read_burst_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic [15:0] dqOut,
  input wire logic        dqOe,
  input wire logic [1:0]  invOut,
  input wire logic [1:0]  invOe,
  input wire logic        odtActive,
  input wire logic        prechargeStart
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // first preamble bit right after the high lead
  sequence s_pre_first;
    dqOe && dqOut == read_burst_pkg::EVEN_LINES
      && $past(dqOut) == read_burst_pkg::ALL_HIGH;
  endsequence

  a_lead_high: assert property (
    $rose(dqOe) |-> dqOut == read_burst_pkg::ALL_HIGH && !odtActive)
    else $error("lead not high with termination off");
  a_odt_driven: assert property (!odtActive |-> dqOe)
    else $error("termination off while pins released");
  a_inv_data: assert property (invOe != 2'b00 |-> dqOe)
    else $error("inversion pin driven outside a read");
  a_inv_bytes: assert property (invOe[1] == invOe[0])
    else $error("byte lanes disagree");
  a_pre_inv: assert property (
    s_pre_first |-> invOe == 2'b00 || invOut == 2'b00)
    else $error("inversion pin preamble not starting low");
  a_pre_toggle: assert property (
    s_pre_first |-> ##[1:6] dqOut == read_burst_pkg::ODD_LINES)
    else $error("preamble not toggling");
  a_tail_high: assert property (
    $fell(dqOe) |-> $past(dqOut) == read_burst_pkg::ALL_HIGH)
    else $error("burst not ended high");
  a_odt_back: assert property ($fell(dqOe) |-> ##[0:8] odtActive)
    else $error("termination not restored");
  a_pre_pulse: assert property (
    $rose(prechargeStart) |=> !prechargeStart)
    else $error("precharge pulse too long");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  a_reset_idle: assert property ($fell(sys_rst) |-> !dqOe && odtActive)
    else $error("pins not idle after reset");
endmodule

bind read_burst_preamble_timing read_burst_asserts i_read_burst_asserts (
  .clk(clk), .sys_rst(sys_rst), .regRead(regRead), .regRdata(regRdata),
  .dqOut(dqOut), .dqOe(dqOe), .invOut(invOut), .invOe(invOe),
  .odtActive(odtActive), .prechargeStart(prechargeStart));

`default_nettype wire

// ### link_partner.sv
`timescale 1ns/10ps
`default_nettype none

module link_partner (
  output var  logic        dataClockPin,
  input  wire logic [21:0] pins
);
  logic [21:0] log [1024];
  int          cnt = 0;

  // free-running data clock, phase apart from clk
  initial begin
    dataClockPin = 1'b0;
    #2;
    forever #40 dataClockPin = ~dataClockPin;
  end

  // capture pins once per bit time
  always @(dataClockPin) begin
    log[cnt[9:0]] = pins;
    cnt++;
  end
endmodule

`default_nettype wire

// ### read_burst_preamble_timing_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module read_burst_preamble_timing_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        dataClockPin;
  logic [15:0] arrayData = 16'h0000;
  logic        arrayValid = 1'b0;
  logic        arrayReady;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdata;
  logic [15:0] dqOut;
  logic        dqOe;
  logic [1:0]  invOut;
  logic [1:0]  invOe;
  logic        odtActive;
  logic        prechargeStart;
  logic [3:0]  prechargeBank;
  int          fed = 0;
  int          lim = 0;
  int          err_count = 0;
  int          n_checks = 0;
  read_burst_pkg::readCmd_type readCmd = '0;

  always #4 clk = ~clk;

  read_burst_preamble_timing i_read_burst_preamble_timing (
    .clk(clk), .sys_rst(sys_rst), .dataClockPin(dataClockPin),
    .readCmd(readCmd), .arrayData(arrayData), .arrayValid(arrayValid),
    .arrayReady(arrayReady), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .dqOut(dqOut), .dqOe(dqOe), .invOut(invOut), .invOe(invOe),
    .odtActive(odtActive), .prechargeStart(prechargeStart),
    .prechargeBank(prechargeBank));

  link_partner i_link_partner (
    .dataClockPin(dataClockPin),
    .pins({invOe, invOut, odtActive, dqOe, dqOut}));

  // array side: word n is {n*13h, ~n*13h}, offered up to lim
  always @(posedge clk) begin
    int n;
    n = fed + int'(arrayValid && arrayReady);
    fed <= n;
    arrayValid <= n < lim;
    arrayData <= {8'(n) * 8'h13, ~(8'(n) * 8'h13)};
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check("regRdata", regRdata, e);
  endtask

  function automatic logic [8:0] enc(input logic [7:0] v, input logic inv);
    return (inv && $countones(~v) > 4) ? {1'b0, ~v} : {1'b1, v};
  endfunction

  task automatic t_regs;
    rd(read_burst_pkg::MODE_ZERO_OFFSET, 32'h0C);
    rd(read_burst_pkg::MODE_ONE_OFFSET, 32'h100);
    rd(read_burst_pkg::MODE_SEVEN_OFFSET, 32'h0);
    rd(read_burst_pkg::CONTROL_OFFSET, 32'h4201);
    wr(read_burst_pkg::STATUS_OFFSET, 32'hFF);
    rd(read_burst_pkg::STATUS_OFFSET, 32'h0);
    rd(8'h14, 32'h0);
    $display("register test done");
  endtask

  task automatic burst(input logic pre, inv, input int lat);
    logic [21:0] e, m;
    logic [8:0]  hi, lo;
    int          c, b, d, j;
    wr(read_burst_pkg::MODE_ZERO_OFFSET, 32'(lat));
    wr(read_burst_pkg::MODE_ONE_OFFSET, {23'h0, !inv, 8'h00});
    wr(read_burst_pkg::MODE_SEVEN_OFFSET, {26'h0, pre, 5'h00});
    @(posedge clk);
    lim <= lim + 16;
    repeat (20) @(posedge clk);
    check("arrayReady full", 32'(arrayReady), 32'h0);
    @(dataClockPin);
    @(posedge clk);
    readCmd <= '{1'b1, 1'b0, 4'h3};
    c = i_link_partner.cnt;
    @(posedge clk);
    readCmd <= '0;
    repeat (2 * lat + 20) @(dataClockPin);
    b = c - 1 + 2 * lat - (pre ? 10 : 2);
    for (j = b - 1; j < c + 2 * lat + 17; j++) begin
      d = j - c + 1 - 2 * lat;
      // element d of this burst is word lim - 16 + d of the feeder
      hi = enc(8'(lim - 16 + d) * 8'h13, inv);
      lo = enc(~(8'(lim - 16 + d) * 8'h13), inv);
      if (j < b || d > 16) {e, m} = {22'h020000, 22'h330000};
      else if (j < b + 2) {e, m} = {22'h01FFFF, 22'h03FFFF};
      else if (d == 16) {e, m} = {22'h01FFFF, 22'h01FFFF};
      else begin
        m = {2'b11, {2{inv}}, 18'h3FFFF};
        e = {{2{inv}}, hi[8], lo[8], 2'b01, hi[7:0], lo[7:0]};
        if (d < 0) e = {{2{inv}}, {2{d[0]}}, 2'b01, {8{d[0], !d[0]}}};
      end
      check("pins", 32'(i_link_partner.log[j] & m), 32'(e & m));
    end
    check("arrayReady drained", 32'(arrayReady), 32'h1);
    $display("burst test done");
  endtask

  task automatic t_precharge;
    int n, k, r;
    for (k = 0; k < 2; k++) begin
      r = k ? read_burst_pkg::RTP_LONG_RESET
            : read_burst_pkg::RTP_SHORT_RESET;
      wr(read_burst_pkg::CONTROL_OFFSET, k ? 32'h4203 : 32'h4201);
      @(posedge clk);
      readCmd <= '{1'b1, 1'b1, 4'(k + 5)};
      @(posedge clk);
      readCmd <= '0;
      for (n = 1; n < 100; n++) begin
        @(posedge clk);
        #1;
        if (prechargeStart === 1'b1) break;
      end
      // ten clk cycles per data clock period, pulse on the r-th rise
      check("precharge delay", 32'(n > 10 * r - 10 && n <= 10 * r), 1);
      check("prechargeBank", 32'(prechargeBank), 32'(k + 5));
      repeat (60) @(dataClockPin);
    end
    $display("precharge test done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    burst(1'b1, 1'b1, 12);
    burst(1'b0, 1'b0, 8);
    burst(1'b1, 1'b0, 10);
    t_precharge;
    finish_test;
  end

  initial begin
    #100000;
    err_count++;
    finish_test;
  end
endmodule

`default_nettype wire
